// File: rtl/adcs_anc_fifo.sv
// Purpose: Byte buffer for ancillary frame data
// Assumes: Writer honours ready; reader pops only when not empty
// Notes:   Head byte is visible without popping

`timescale 1ns/1ps
`default_nettype none

module adcs_anc_fifo (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ready_o,
   input wire logic rd_pop_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o
);

   logic [7:0] mem_q [adcs_pkg::ANC_DEPTH];
   logic [adcs_pkg::ANC_AW-1:0] wr_ptr_q;
   logic [adcs_pkg::ANC_AW-1:0] rd_ptr_q;
   logic [adcs_pkg::ANC_AW:0] count_q;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // Handshake terms
   // ----------------------------------------------------------------
   assign wr_ready_o = (count_q != 6'(adcs_pkg::ANC_DEPTH));
   assign rd_valid_o = (count_q != 6'h00);
   assign push = wr_valid_i && wr_ready_o;
   assign pop = rd_pop_i && rd_valid_o;
   assign rd_data_o = mem_q[rd_ptr_q];

   // Storage array
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data_i;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else if (flush_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 5'h01;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 5'h01;
         end
         count_q <= count_q + 6'(push) - 6'(pop);
      end
   end

endmodule : adcs_anc_fifo

`default_nettype wire

// File: rtl/adcs_err_flags.sv
// Purpose: Sticky error flags, cleared by a status read
// Assumes: Set and clear inputs come from the same clock domain
// Notes:   A set with the clear wins

`timescale 1ns/1ps
`default_nettype none

module adcs_err_flags (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [2:0] set_i,
   input wire logic clear_i,
   output logic [2:0] flags_o
);

   // ----------------------------------------------------------------
   // Flag storage
   // ----------------------------------------------------------------
   // Clear first, then set, so the set takes priority
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_o <= 3'h0;
      end else begin
         flags_o <= (clear_i ? 3'h0 : flags_o) | set_i;
      end
   end

endmodule : adcs_err_flags

`default_nettype wire

// File: rtl/adcs_pkg.sv
// Purpose: Shared constants and types for the audio decoder control and status block
// Assumes: 8-bit special function register space of the host core, one clock
// Notes:   All offsets, fields and reset values

package adcs_pkg;

   // ----------------------------------------------------------------
   // Register addresses in the special function register space
   // ----------------------------------------------------------------
   localparam logic [7:0] LEFT_VOLUME_ADDR = 8'h9E;
   localparam logic [7:0] RIGHT_VOLUME_ADDR = 8'h9F;
   localparam logic [7:0] CONTROL_ADDR = 8'hAA;
   localparam logic [7:0] STREAM_INPUT_ADDR = 8'hAC;
   localparam logic [7:0] ANCILLARY_ADDR = 8'hAD;
   localparam logic [7:0] LOW_BAND_ADDR = 8'hB4;
   localparam logic [7:0] MID_BAND_ADDR = 8'hB5;
   localparam logic [7:0] HIGH_BAND_ADDR = 8'hB6;
   localparam logic [7:0] STATUS_ADDR = 8'hC8;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_BOOST_BIT = 6;
   localparam int CTL_PLAY_BAD_BIT = 5;
   localparam int CTL_MASK_ANC_BIT = 4;
   localparam int CTL_MASK_REQ_BIT = 3;
   localparam int CTL_MASK_LAY_BIT = 2;
   localparam int CTL_MASK_SYN_BIT = 1;
   localparam int CTL_MASK_CRC_BIT = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h3F;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int STA_ANC_BIT = 7;
   localparam int STA_REQ_BIT = 6;
   localparam int STA_LAY_BIT = 5;
   localparam int STA_SYN_BIT = 4;
   localparam int STA_CRC_BIT = 3;
   localparam int STA_RATE_LSB = 1;
   localparam int STA_VER_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h01;

   // ----------------------------------------------------------------
   // Gain codes, band edges and buffer sizes
   // ----------------------------------------------------------------
   localparam int GAIN_W = 5;
   localparam logic [4:0] GAIN_MUTE_CODE = 5'h00;
   localparam logic [4:0] GAIN_RESET = 5'h00;
   localparam int LOW_BAND_EDGE_HZ = 750;
   localparam int HIGH_BAND_EDGE_HZ = 3300;
   localparam int BOOST_EDGE_HZ = 375;
   localparam int BOOST_GAIN_DB = 9;
   localparam logic [10:0] FIRST_FILL_BYTES = 11'h400;
   localparam int ANC_DEPTH = 32;
   localparam int ANC_AW = 5;
   localparam int ERR_COUNT = 3;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic bass_boost_en;
      logic [4:0] left_volume_code;
      logic [4:0] right_volume_code;
      logic [4:0] low_band_gain;
      logic [4:0] mid_band_gain;
      logic [4:0] high_band_gain;
      logic left_mute;
      logic right_mute;
   } adcs_audio_cfg_t;

   typedef struct packed {
      logic layer_err;
      logic sync_err;
      logic crc_err;
      logic hdr_valid;
      logic stream_version;
      logic [1:0] sample_rate_code;
   } adcs_dec_evt_t;

endpackage : adcs_pkg

// File: rtl/adcs_top.sv
// Purpose: Control, status and interrupt front end of the audio decoder
// Assumes: Host core reaches registers over its SFR bus
// Notes:   Decoder datapath is outside, on the same clock
//
// Contract
// - Separate 5-bit volumes; 0 mutes, 31 is 0 dB.
// - Equalizer bands split at 750 Hz and 3300 Hz.
// - 5-bit gain per band; 0 is minus infinity.
// - Bass boost adds 9 dB below 375 Hz.
// - Unsupported layer sets the layer error flag.
// - Missing sync pattern sets the sync error flag.
// - CRC mismatch sets the checksum error flag.
// - Control bit 5 set plays bad-CRC frames, else skips.
// - Version bit and rate code give the sample rate.
// - Version bit is 1 for version one, 0 for two.
// - Ancillary bytes buffered; flag set while buffer not empty.
// - Five sources form one interrupt; set mask bit blocks.
// - Control: enable 7, boost 6, CRC policy 5, masks 4..0.
// - Interrupt needs decoder and global enables set.
// - Status read clears error flags, not request or ancillary.
// - Hardware clears request once the decoder stops asking.
// - Enable bit starts the decoder; clear stops it.
// - First request after enable asks 1024 bytes.

`timescale 1ns/1ps
`default_nettype none

module adcs_top (
   input wire logic clk_i,
   input wire logic resetn_i,
   // Special function register bus of the host core
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // Interrupt enables held in the core's enable register
   input wire logic decoder_irq_enable_i,
   input wire logic global_irq_enable_i,
   // Decoder datapath side
   input wire adcs_pkg::adcs_dec_evt_t dec_evt_i,
   input wire logic dec_need_data_i,
   input wire logic anc_valid_i,
   input wire logic [7:0] anc_byte_i,
   output logic anc_ready_o,
   output logic decoder_enable_o,
   output logic frame_skip_o,
   output logic [7:0] stream_byte_o,
   output logic stream_valid_o,
   output adcs_pkg::adcs_audio_cfg_t audio_cfg_o,
   output logic irq_req_o,
   output logic cpu_irq_o
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Gain code zero means silence for volume and band gains
   function automatic logic code_is_mute(input logic [4:0] code);
      code_is_mute = (code == adcs_pkg::GAIN_MUTE_CODE);
   endfunction : code_is_mute

   // Keeps the 5-bit gain field of a written byte
   function automatic logic [4:0] gain_field(input logic [7:0] data);
      gain_field = data[adcs_pkg::GAIN_W-1:0];
   endfunction : gain_field

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FILL_IDLE = 2'b00,
      FILL_FIRST = 2'b01,
      FILL_RUN = 2'b11
   } adcs_fill_state_t;

   logic [7:0] control_q;
   logic [4:0] left_vol_q;
   logic [4:0] right_vol_q;
   logic [4:0] low_gain_q;
   logic [4:0] mid_gain_q;
   logic [4:0] high_gain_q;
   logic stream_version_q;
   logic [1:0] sample_rate_q;
   logic data_request_q;
   logic [10:0] fill_count_q;
   adcs_fill_state_t fill_state_q;
   logic enable_d1_q;
   logic [2:0] err_flags;
   logic [2:0] err_set;
   logic anc_head_valid;
   logic [7:0] anc_head;
   logic [7:0] status_value;
   logic [7:0] read_value;
   logic [4:0] source_flags;
   logic [4:0] source_masks;
   logic irq_level;
   logic wr_control;
   logic wr_stream;
   logic rd_status;
   logic rd_anc;
   logic enable_bit;
   logic enable_rise;
   logic fill_last;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Strobes for registers with side effects
   assign wr_control = sfr_wr_i && (sfr_addr_i == adcs_pkg::CONTROL_ADDR);
   assign wr_stream = sfr_wr_i && (sfr_addr_i == adcs_pkg::STREAM_INPUT_ADDR);
   assign rd_status = sfr_rd_i && (sfr_addr_i == adcs_pkg::STATUS_ADDR);
   assign rd_anc = sfr_rd_i && (sfr_addr_i == adcs_pkg::ANCILLARY_ADDR);

   assign enable_bit = control_q[adcs_pkg::CTL_ENABLE_BIT];
   assign enable_rise = enable_bit && !enable_d1_q;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Enable, boost, CRC policy and five source masks
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         control_q <= adcs_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         control_q <= sfr_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Volume and equalizer registers
   // ----------------------------------------------------------------
   // Volume codes per channel
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         left_vol_q <= adcs_pkg::GAIN_RESET;
         right_vol_q <= adcs_pkg::GAIN_RESET;
      end else if (sfr_wr_i) begin
         if (sfr_addr_i == adcs_pkg::LEFT_VOLUME_ADDR) begin
            left_vol_q <= gain_field(sfr_wdata_i);
         end else if (sfr_addr_i == adcs_pkg::RIGHT_VOLUME_ADDR) begin
            right_vol_q <= gain_field(sfr_wdata_i);
         end
      end
   end

   // Band gain codes for low, middle and high bands
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_gain_q <= adcs_pkg::GAIN_RESET;
         mid_gain_q <= adcs_pkg::GAIN_RESET;
         high_gain_q <= adcs_pkg::GAIN_RESET;
      end else if (sfr_wr_i) begin
         if (sfr_addr_i == adcs_pkg::LOW_BAND_ADDR) begin
            low_gain_q <= gain_field(sfr_wdata_i);
         end else if (sfr_addr_i == adcs_pkg::MID_BAND_ADDR) begin
            mid_gain_q <= gain_field(sfr_wdata_i);
         end else if (sfr_addr_i == adcs_pkg::HIGH_BAND_ADDR) begin
            high_gain_q <= gain_field(sfr_wdata_i);
         end
      end
   end

   // Settings handed to the datapath, registered
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         audio_cfg_o <= '0;
         decoder_enable_o <= 1'b0;
      end else begin
         audio_cfg_o.bass_boost_en <= control_q[adcs_pkg::CTL_BOOST_BIT];
         audio_cfg_o.left_volume_code <= left_vol_q;
         audio_cfg_o.right_volume_code <= right_vol_q;
         audio_cfg_o.low_band_gain <= low_gain_q;
         audio_cfg_o.mid_band_gain <= mid_gain_q;
         audio_cfg_o.high_band_gain <= high_gain_q;
         audio_cfg_o.left_mute <= code_is_mute(left_vol_q);
         audio_cfg_o.right_mute <= code_is_mute(right_vol_q);
         decoder_enable_o <= enable_bit;
      end
   end

   // ----------------------------------------------------------------
   // Decoding errors and frame information
   // ----------------------------------------------------------------
   // Error events in order layer, sync, crc
   assign err_set = {dec_evt_i.layer_err, dec_evt_i.sync_err, dec_evt_i.crc_err};

   adcs_err_flags u_err_flags (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .set_i(err_set),
      .clear_i(rd_status),
      .flags_o(err_flags)
   );

   // Skip bad-CRC frames unless policy says play
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         frame_skip_o <= 1'b0;
      end else begin
         frame_skip_o <= dec_evt_i.crc_err && !control_q[adcs_pkg::CTL_PLAY_BAD_BIT];
      end
   end

   // Version and rate from each header
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stream_version_q <= adcs_pkg::STATUS_RESET[adcs_pkg::STA_VER_BIT];
         sample_rate_q <= 2'h0;
      end else if (dec_evt_i.hdr_valid) begin
         stream_version_q <= dec_evt_i.stream_version;
         sample_rate_q <= dec_evt_i.sample_rate_code;
      end
   end

   // ----------------------------------------------------------------
   // Stream input and data request
   // ----------------------------------------------------------------
   // Host bytes pass to the decoder input
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stream_byte_o <= 8'h00;
         stream_valid_o <= 1'b0;
      end else begin
         stream_valid_o <= wr_stream;
         if (wr_stream) begin
            stream_byte_o <= sfr_wdata_i;
         end
      end
   end

   assign fill_last = (fill_count_q == adcs_pkg::FIRST_FILL_BYTES - 11'h001);

   // First request after enable covers a full buffer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fill_state_q <= FILL_IDLE;
         fill_count_q <= 11'h000;
         enable_d1_q <= 1'b0;
      end else begin
         enable_d1_q <= enable_bit;
         case (fill_state_q)
            FILL_IDLE: begin
               fill_count_q <= 11'h000;
               if (enable_rise) begin
                  fill_state_q <= FILL_FIRST;
               end
            end
            FILL_FIRST: begin
               if (!enable_bit) begin
                  fill_state_q <= FILL_IDLE;
               end else if (wr_stream) begin
                  fill_count_q <= fill_count_q + 11'h001;
                  if (fill_last) begin
                     fill_state_q <= FILL_RUN;
                  end
               end
            end
            FILL_RUN: begin
               if (!enable_bit) begin
                  fill_state_q <= FILL_IDLE;
               end
            end
            default: begin
               fill_state_q <= FILL_IDLE;
            end
         endcase
      end
   end

   // Request flag, dropped by hardware once satisfied
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_request_q <= 1'b0;
      end else begin
         data_request_q <= (fill_state_q == FILL_FIRST) ||
                           ((fill_state_q == FILL_RUN) && dec_need_data_i);
      end
   end

   // ----------------------------------------------------------------
   // Ancillary data buffer
   // ----------------------------------------------------------------
   // Reading the ancillary register pops the head byte
   adcs_anc_fifo u_anc_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .flush_i(enable_rise),
      .wr_valid_i(anc_valid_i),
      .wr_data_i(anc_byte_i),
      .wr_ready_o(anc_ready_o),
      .rd_pop_i(rd_anc),
      .rd_data_o(anc_head),
      .rd_valid_o(anc_head_valid)
   );

   // ----------------------------------------------------------------
   // Status and read data
   // ----------------------------------------------------------------
   // Status byte assembled from live flags
   always_comb begin
      status_value = 8'h00;
      status_value[adcs_pkg::STA_ANC_BIT] = anc_head_valid;
      status_value[adcs_pkg::STA_REQ_BIT] = data_request_q;
      status_value[adcs_pkg::STA_LAY_BIT] = err_flags[2];
      status_value[adcs_pkg::STA_SYN_BIT] = err_flags[1];
      status_value[adcs_pkg::STA_CRC_BIT] = err_flags[0];
      status_value[adcs_pkg::STA_RATE_LSB +: 2] = sample_rate_q;
      status_value[adcs_pkg::STA_VER_BIT] = stream_version_q;
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      read_value = 8'h00;
      if (sfr_addr_i == adcs_pkg::CONTROL_ADDR) begin
         read_value = control_q;
      end else if (sfr_addr_i == adcs_pkg::STATUS_ADDR) begin
         read_value = status_value;
      end else if (sfr_addr_i == adcs_pkg::ANCILLARY_ADDR) begin
         read_value = anc_head_valid ? anc_head : 8'h00;
      end else if (sfr_addr_i == adcs_pkg::LEFT_VOLUME_ADDR) begin
         read_value = {3'h0, left_vol_q};
      end else if (sfr_addr_i == adcs_pkg::RIGHT_VOLUME_ADDR) begin
         read_value = {3'h0, right_vol_q};
      end else if (sfr_addr_i == adcs_pkg::LOW_BAND_ADDR) begin
         read_value = {3'h0, low_gain_q};
      end else if (sfr_addr_i == adcs_pkg::MID_BAND_ADDR) begin
         read_value = {3'h0, mid_gain_q};
      end else if (sfr_addr_i == adcs_pkg::HIGH_BAND_ADDR) begin
         read_value = {3'h0, high_gain_q};
      end
   end

   // Read data loaded on a read strobe and held
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= read_value;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt combination
   // ----------------------------------------------------------------
   // Sources and masks in order anc, req, lay, syn, crc
   assign source_flags = {anc_head_valid, data_request_q, err_flags};
   assign source_masks = control_q[adcs_pkg::CTL_MASK_ANC_BIT:adcs_pkg::CTL_MASK_CRC_BIT];
   assign irq_level = |(source_flags & ~source_masks);

   // Level request and the gated line to the core
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_req_o <= 1'b0;
         cpu_irq_o <= 1'b0;
      end else begin
         irq_req_o <= irq_level;
         cpu_irq_o <= irq_level && decoder_irq_enable_i && global_irq_enable_i;
      end
   end

endmodule : adcs_top

`default_nettype wire

// File: tb/adcs_host_model.sv
// Purpose: Host core model on the register bus
// Assumes: Tasks are entered just after a falling edge
// Notes:   Strobes stay up until the next call or idle, so accesses abut
`timescale 1ns/1ps
`default_nettype none
module adcs_host_model (
   input wire logic clk_i,
   input wire logic [7:0] sfr_rdata_i,
   output logic [7:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   output logic sfr_wr_o,
   output logic sfr_rd_o,
   output logic dec_irq_en_o,
   output logic glob_irq_en_o
);
   // Quiet bus at time zero
   initial {sfr_addr_o, sfr_wdata_o, sfr_wr_o, sfr_rd_o, dec_irq_en_o, glob_irq_en_o} = '0;
   // One write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {sfr_addr_o, sfr_wdata_o, sfr_wr_o, sfr_rd_o} = {a, d, 2'b10};
      @(negedge clk_i);
   endtask : wr
   // One read cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      {sfr_addr_o, sfr_wr_o, sfr_rd_o} = {a, 2'b01};
      @(negedge clk_i);
      d = sfr_rdata_i;
   endtask : rd
   // Release; address and data flip
   task automatic idle();
      {sfr_addr_o, sfr_wdata_o, sfr_wr_o, sfr_rd_o} = {~sfr_addr_o, ~sfr_wdata_o, 2'b00};
      @(negedge clk_i);
   endtask : idle
   // Core interrupt enables
   task automatic irq_en(input logic de, input logic ge);
      {dec_irq_en_o, glob_irq_en_o} = {de, ge};
      @(negedge clk_i);
   endtask : irq_en
   // Stream bytes, one write per cycle, not waiting for a request
   task automatic feed(input int n);
      for (int i = 0; i < n; i++) wr(adcs_pkg::STREAM_INPUT_ADDR, i[7:0] ^ 8'h5A);
   endtask : feed
endmodule : adcs_host_model
`default_nettype wire

// File: tb/adcs_top_chk.sv
// Purpose: Port checker for the decoder control block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Control register is shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module adcs_top_chk (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic decoder_irq_enable_i,
   input wire logic global_irq_enable_i,
   input wire adcs_pkg::adcs_dec_evt_t dec_evt_i,
   input wire logic frame_skip_o,
   input wire logic [7:0] stream_byte_o,
   input wire logic stream_valid_o,
   input wire logic irq_req_o,
   input wire logic cpu_irq_o
);
   logic [7:0] ctl_q;
   logic sta_rd;
   logic st_wr;
   logic [2:0] err;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Decodes and error bundle
   assign sta_rd = sfr_rd_i && sfr_addr_i == adcs_pkg::STATUS_ADDR;
   assign st_wr = sfr_wr_i && sfr_addr_i == adcs_pkg::STREAM_INPUT_ADDR;
   assign err = {dec_evt_i.layer_err, dec_evt_i.sync_err, dec_evt_i.crc_err};
   // Control shadow
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) ctl_q <= adcs_pkg::CONTROL_RESET;
      else if (sfr_wr_i && sfr_addr_i == adcs_pkg::CONTROL_ADDR) ctl_q <= sfr_wdata_i;
   end
   cpu_gate_a: assert property (
      cpu_irq_o == (irq_req_o && $past(decoder_irq_enable_i) && $past(global_irq_enable_i)))
      else $error("cpu interrupt gating wrong");
   skip_policy_a: assert property (frame_skip_o == $past(dec_evt_i.crc_err && !ctl_q[5]))
      else $error("frame skip wrong");
   stream_echo_a: assert property (
      stream_valid_o == $past(st_wr) && (!stream_valid_o || stream_byte_o == $past(sfr_wdata_i)))
      else $error("stream byte wrong");
   err_clear_a: assert property (sta_rd && err == 3'h0 ##1 sta_rd && err == 3'h0 |=> sfr_rdata_o[5:3] == 3'h0)
      else $error("error flags not cleared by read");
   err_capture_a: assert property (sta_rd |=> (sfr_rdata_o[5:3] & $past(err, 2)) == $past(err, 2))
      else $error("error flag not set");
   frame_info_a: assert property (sta_rd && $past(dec_evt_i.hdr_valid) |=>
      sfr_rdata_o[2:0] == {$past(dec_evt_i.sample_rate_code, 2), $past(dec_evt_i.stream_version, 2)})
      else $error("frame info wrong");
   irq_raise_a: assert property (err != 3'h0 ##1 ($past(err) & ~ctl_q[2:0]) != 3'h0 |=> irq_req_o)
      else $error("interrupt not raised");
   mask_block_a: assert property ($past(ctl_q[4:0]) == 5'h1F |-> !irq_req_o)
      else $error("masked interrupt raised");
endmodule : adcs_top_chk
bind adcs_top adcs_top_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
   .decoder_irq_enable_i(decoder_irq_enable_i), .global_irq_enable_i(global_irq_enable_i),
   .dec_evt_i(dec_evt_i), .frame_skip_o(frame_skip_o), .stream_byte_o(stream_byte_o),
   .stream_valid_o(stream_valid_o), .irq_req_o(irq_req_o), .cpu_irq_o(cpu_irq_o));
`default_nettype wire

// File: tb/audio_decoder_ctrl_status_test.sv
// Purpose: Self-checking bench for the decoder control block
// Assumes: Inputs change on the falling clock edge
// Notes:   Decoder data need held low, so requests end after the first fill
`timescale 1ns/1ps
`default_nettype none
module audio_decoder_ctrl_status_test;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr, wdata, rdata, sts, d, sbyte;
   logic [7:0] anc_byte = 8'h00;
   logic wr, rd, de, ge, anc_ready, dec_en, skip, svalid, irq_req, cpu_irq;
   logic anc_valid = 1'b0;
   adcs_pkg::adcs_dec_evt_t evt = '0;
   adcs_pkg::adcs_audio_cfg_t cfg;
   int n_fail = 0;
   int num_checks = 0;
   int k = 0;
   // Clock
   always #2 clk_i = ~clk_i;
   adcs_host_model u_host (.clk_i(clk_i), .sfr_rdata_i(rdata), .sfr_addr_o(addr), .sfr_wdata_o(wdata),
      .sfr_wr_o(wr), .sfr_rd_o(rd), .dec_irq_en_o(de), .glob_irq_en_o(ge));
   adcs_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .decoder_irq_enable_i(de),
      .global_irq_enable_i(ge), .dec_evt_i(evt), .dec_need_data_i(1'b0), .anc_valid_i(anc_valid),
      .anc_byte_i(anc_byte), .anc_ready_o(anc_ready), .decoder_enable_o(dec_en), .frame_skip_o(skip),
      .stream_byte_o(sbyte), .stream_valid_o(svalid), .audio_cfg_o(cfg), .irq_req_o(irq_req),
      .cpu_irq_o(cpu_irq));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
      u_host.rd(a, d);
      chk(n, e, d);
   endtask : rdchk
   // One-cycle decoder event pulse
   task automatic ev(input logic [6:0] v);
      evt = v;
      @(negedge clk_i);
      evt = '0;
   endtask : ev
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end
   // Main sequence
   initial begin
      repeat (6) @(negedge clk_i);
      resetn_i = 1'b1;
      rdchk(adcs_pkg::CONTROL_ADDR, adcs_pkg::CONTROL_RESET, "control");
      rdchk(adcs_pkg::STATUS_ADDR, adcs_pkg::STATUS_RESET, "status");
      rdchk(8'h01, 8'h00, "unmapped");
      u_host.wr(adcs_pkg::LEFT_VOLUME_ADDR, 8'h00);
      u_host.wr(adcs_pkg::RIGHT_VOLUME_ADDR, 8'h1F);
      u_host.wr(adcs_pkg::LOW_BAND_ADDR, 8'h01);
      u_host.wr(adcs_pkg::MID_BAND_ADDR, 8'h10);
      u_host.wr(adcs_pkg::HIGH_BAND_ADDR, 8'h1F);
      u_host.wr(adcs_pkg::CONTROL_ADDR, 8'hC8);
      repeat (2) u_host.idle();
      chk("cfg", {1'b1, 5'h00, 5'h1F, 5'h01, 5'h10, 5'h1F, 1'b1, 1'b0}, cfg);
      chk("enable", 1'b1, dec_en);
      rdchk(adcs_pkg::CONTROL_ADDR, 8'hC8, "control");
      u_host.idle();
      u_host.irq_en(1'b1, 1'b1);
      ev(7'h79);
      chk("skip", 1'b1, skip);
      @(negedge clk_i);
      chk("irq", 1'b1, irq_req);
      chk("cpu irq", 1'b1, cpu_irq);
      u_host.irq_en(1'b1, 1'b0);
      @(negedge clk_i);
      chk("cpu irq", 1'b0, cpu_irq);
      u_host.rd(adcs_pkg::STATUS_ADDR, sts);
      chk("status", 8'h7A, sts);
      rdchk(adcs_pkg::STATUS_ADDR, 8'h42, "status");
      u_host.wr(adcs_pkg::CONTROL_ADDR, 8'hFF);
      repeat (2) u_host.idle();
      chk("irq", 1'b0, irq_req);
      ev(7'h19);
      chk("skip", 1'b0, skip);
      rdchk(adcs_pkg::STATUS_ADDR, 8'h4A, "status");
      u_host.feed(1023);
      rdchk(adcs_pkg::STATUS_ADDR, 8'h42, "status");
      u_host.feed(1);
      repeat (2) u_host.idle();
      rdchk(adcs_pkg::STATUS_ADDR, 8'h02, "status");
      u_host.idle();
      chk("anc ready", 1'b1, anc_ready);
      {anc_valid, anc_byte} = {1'b1, 8'hA5};
      @(negedge clk_i);
      anc_byte = 8'h3C;
      @(negedge clk_i);
      anc_valid = 1'b0;
      for (int i = 0; i < 4; i++) begin
         u_host.rd(adcs_pkg::STATUS_ADDR, sts);
         if (sts[adcs_pkg::STA_ANC_BIT] !== 1'b1) break;
         u_host.rd(adcs_pkg::ANCILLARY_ADDR, d);
         chk("anc byte", (k == 0) ? 8'hA5 : 8'h3C, d);
         k++;
      end
      chk("anc count", 2, k);
      u_host.idle();
      end_of_test();
   end
endmodule : audio_decoder_ctrl_status_test
`default_nettype wire
